// ==== hw/axb_pkg.sv ====
/*
 * Shared constants, types and cipher helper functions for the XTS block cipher.
 * Assumes one system clock; all functions are pure combinational helpers.
 */
package axb_pkg;
    localparam logic [31:0] VERSION    = 32'h0000_0001;  // Arbitrary version code
    localparam logic [3:0]  KEY_CYCLES = 4'he;            // Key setting length in clocks
    localparam logic [3:0]  KEY_LAST   = KEY_CYCLES - 4'h1;
    localparam logic [3:0]  NROUNDS    = 4'he;            // AES-256 round count
    localparam logic [7:0]  RED_POLY   = 8'h1b;           // GF(2^8) reduction
    localparam logic [7:0]  XTS_POLY   = 8'h87;           // GF(2^128) reduction
    localparam logic [7:0]  SBOX_C     = 8'h63;
    localparam logic [7:0]  ISBOX_C    = 8'h05;

    // One-hot sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_TWK  = 5'h02,
        ST_READ = 5'h04,
        ST_CIPH = 5'h08,
        ST_TAIL = 5'h10
    } axb_state_t;

    // Operation request captured at start
    typedef struct packed {
        logic [127:0] init_vector;
        logic [15:0]  msg_byte_count;
    } axb_req_t;

    function automatic logic [7:0] xt(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? RED_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i]) p = p ^ x;
            x = xt(x);
        end
        return p;
    endfunction

    // Inverse as x^254; costs area but avoids a 256-entry table
    function automatic logic [7:0] ginv(input logic [7:0] x);
        logic [7:0] p;
        logic [7:0] r;
        p = x;
        r = 8'h01;
        for (int i = 1; i < 8; i++)
        begin
            p = gmul(p, p);
            r = gmul(r, p);
        end
        return r;
    endfunction

    function automatic logic [7:0] sbox(input logic [7:0] x);
        logic [7:0] b;
        b = ginv(x);
        return b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]} ^ {b[3:0], b[7:4]} ^ SBOX_C;
    endfunction

    function automatic logic [7:0] isbox(input logic [7:0] s);
        return ginv({s[6:0], s[7]} ^ {s[4:0], s[7:5]} ^ {s[1:0], s[7:2]} ^ ISBOX_C);
    endfunction

    function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
        logic [7:0]   a [4];
        logic [127:0] t;
        t = '0;
        for (int c = 0; c < 4; c++)
        begin
            for (int r = 0; r < 4; r++) a[r] = s[127-8*(4*c+r) -: 8];
            for (int r = 0; r < 4; r++)
                t[127-8*(4*c+r) -: 8] = inv ?
                    gmul(a[r], 8'h0e) ^ gmul(a[(r+1)%4], 8'h0b) ^ gmul(a[(r+2)%4], 8'h0d) ^ gmul(a[(r+3)%4], 8'h09) :
                    gmul(a[r], 8'h02) ^ gmul(a[(r+1)%4], 8'h03) ^ a[(r+2)%4] ^ a[(r+3)%4];
        end
        return t;
    endfunction

    function automatic logic [127:0] enc_round(input logic [127:0] s, input logic [127:0] k, input logic last);
        logic [127:0] t;
        t = '0;
        for (int i = 0; i < 16; i++)
            t[127-8*i -: 8] = sbox(s[127-8*((i%4)+4*(((i/4)+(i%4))%4)) -: 8]);
        return (last ? t : mix(t, 1'b0)) ^ k;
    endfunction

    function automatic logic [127:0] dec_round(input logic [127:0] s, input logic [127:0] k, input logic last);
        logic [127:0] t;
        t = '0;
        for (int i = 0; i < 16; i++)
            t[127-8*i -: 8] = isbox(s[127-8*((i%4)+4*(((i/4)-(i%4)+4)%4)) -: 8]);
        return last ? (t ^ k) : mix(t ^ k, 1'b1);
    endfunction

    // Tweak times alpha, bytes taken as a little-endian integer
    function automatic logic [127:0] mul_alpha(input logic [127:0] t);
        logic [127:0] o;
        o = '0;
        for (int j = 0; j < 16; j++)
            o[127-8*j -: 8] = {t[126-8*j -: 7], (j == 0) ? 1'b0 : t[127-8*(j-1)]};
        o[127 -: 8] = o[127 -: 8] ^ (t[7] ? XTS_POLY : 8'h00);
        return o;
    endfunction

    // Next 128-bit slice of the AES-256 key schedule, k = slice index 2..14
    function automatic logic [127:0] key_next(input logic [127:0] p2, input logic [127:0] p1, input logic [3:0] k);
        logic [31:0] w;
        logic [31:0] tmp;
        logic [127:0] n;
        w = k[0] ? p1[31:0] : {p1[23:0], p1[31:24]};
        tmp = {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
        if (!k[0]) tmp[31:24] = tmp[31:24] ^ (8'h01 << (k[3:1] - 3'h1));
        n[127:96] = p2[127:96] ^ tmp;
        n[95:64]  = p2[95:64] ^ n[127:96];
        n[63:32]  = p2[63:32] ^ n[95:64];
        n[31:0]   = p2[31:0] ^ n[63:32];
        return n;
    endfunction
endpackage

// ==== hw/axb_xts_core.sv ====
/*
 * XTS block cipher with ciphertext stealing: key schedule unit and the top core.
 * DECRYPT selects the direction; both builds share one port list.
 * Assumes keys, IV, count and input words come from logic on clk_in, so no synchronisers.
 */
// Contract
// - Reset input is active low and returns all control state to idle.
// - A constant 32-bit version value is always driven out.
// - Each operation uses a 256-bit data key and a 256-bit tweak key.
// - Lengths not a block multiple are finished by ciphertext stealing.
// - Encrypt and decrypt builds share ports and handshake, differ in direction.
// - Data key valid high starts the data key setting.
// - Data key busy rises after valid and stays until the last setting cycle.
// - While data key busy, new data key and start requests are ignored.
// - Data key done pulses in the final setting cycle.
// - Tweak key valid starts tweak key setting, independent of data key.
// - Tweak key busy rises after valid and stays until last setting cycle.
// - While tweak key busy, new tweak key and start requests are ignored.
// - Tweak key done pulses in the final setting cycle.
// - Start input begins one encryption or decryption of a message.
// - Key setting takes fourteen clocks; the key then serves until replaced.
// - IV and byte count valid at start; busy rises the next cycle.
// - Operation done is high exactly one clock, the final operation cycle.
`timescale 1ns/1ps

module axb_key_sched (
    input  wire logic                    clk_in,       // System clock
    input  wire logic                    sys_rst_n_in, // Async reset, low
    input  wire logic                    valid_in,     // Key valid request
    input  wire logic [255:0]            key_in,       // Key value
    input  wire logic                    hold_in,      // Operation running, refuse key
    output logic                         busy_out,     // Setting in progress
    output logic                         done_out,     // Final setting cycle
    output logic      [0:14][127:0]      rk_out        // Expanded round keys
);
    logic        busy_q;
    logic        done_q;
    logic [3:0]  cnt_q;
    logic [0:14][127:0] rk_q;
    logic [127:0] next_rk;

    assign next_rk  = axb_pkg::key_next(rk_q[cnt_q], rk_q[cnt_q + 4'h1], cnt_q + 4'h2);
    assign busy_out = busy_q;
    assign done_out = done_q;
    assign rk_out   = rk_q;

    // One schedule slice per clock; the whole run is one key-setting period
    always_ff @(posedge clk_in or negedge sys_rst_n_in)
    begin
        if (!sys_rst_n_in)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q  <= 4'h0;
            rk_q   <= '0;
        end
        else
        begin
            done_q <= busy_q && (cnt_q == axb_pkg::KEY_LAST - 4'h1);
            if (!busy_q)
            begin
                if (valid_in && !hold_in)
                begin
                    rk_q[0] <= key_in[255:128];
                    rk_q[1] <= key_in[127:0];
                    busy_q  <= 1'b1;
                    cnt_q   <= 4'h0;
                end
            end
            else if (cnt_q == axb_pkg::KEY_LAST)
                busy_q <= 1'b0;
            else
            begin
                rk_q[cnt_q + 4'h2] <= next_rk;
                cnt_q              <= cnt_q + 4'h1;
            end
        end
    end
endmodule

module axb_xts_core #(
    parameter bit DECRYPT = 1'b0                            // 1 builds the decrypt direction
) (
    input  wire logic         clk_in,                 // System clock, 20 MHz
    input  wire logic         sys_rst_n_in,           // Async reset, low
    output logic [31:0]       version_out,            // Constant version
    input  wire logic         data_key_valid_in,      // Data key valid
    input  wire logic [255:0] data_key_in,            // Data key
    output logic              data_key_busy_out,      // Data key setting
    output logic              data_key_done_out,      // Data key last cycle
    input  wire logic         tweak_key_valid_in,     // Tweak key valid
    input  wire logic [255:0] tweak_key_in,           // Tweak key
    output logic              tweak_key_busy_out,     // Tweak key setting
    output logic              tweak_key_done_out,     // Tweak key last cycle
    input  wire logic         op_start_in,            // Start operation
    input  wire logic [127:0] init_vector_in,         // IV
    input  wire logic [15:0]  msg_byte_count_in,      // Message length in bytes
    output logic              op_busy_out,            // Operation running
    output logic              op_done_out,            // Operation last cycle
    output logic              in_word_read_out,       // Input word strobe
    input  wire logic [127:0] in_word_in,             // Input word
    output logic              out_valid_out,          // Output word valid
    output logic [127:0]      out_word_out            // Output word
);
    axb_pkg::axb_state_t st_q;
    axb_pkg::axb_req_t   req;
    logic [0:14][127:0]  drk;
    logic [0:14][127:0]  trk;
    logic [127:0] blk_q, tw_q, twu_q, hold_q, od_q;
    logic [11:0]  left_q;
    logic [3:0]   rnd_q, rem_q;
    logic         kf_q, kfin_q, fin_q, busy_q, done_q, rd_q, ov_q;
    logic [31:0]  ver_q;
    logic         dk_busy, tk_busy;

    // Data key always expands forward; decrypt simply walks it backwards
    axb_key_sched u_dkey (
        .clk_in       (clk_in),
        .sys_rst_n_in (sys_rst_n_in),
        .valid_in     (data_key_valid_in),
        .key_in       (data_key_in),
        .hold_in      (busy_q),
        .busy_out     (dk_busy),
        .done_out     (data_key_done_out),
        .rk_out       (drk)
    );

    axb_key_sched u_tkey (
        .clk_in       (clk_in),
        .sys_rst_n_in (sys_rst_n_in),
        .valid_in     (tweak_key_valid_in),
        .key_in       (tweak_key_in),
        .hold_in      (busy_q),
        .busy_out     (tk_busy),
        .done_out     (tweak_key_done_out),
        .rk_out       (trk)
    );

    // Request decode and stealing selection
    logic         start_ok, steal, cur_first, is_twk, last;
    logic [127:0] tw_adv, head_m, din, tw_use, rk_cur, first_key, r_out, res;
    assign req       = '{init_vector: init_vector_in, msg_byte_count: msg_byte_count_in};
    assign start_ok  = op_start_in && !busy_q && !dk_busy && !tk_busy;
    assign steal     = (rem_q != 4'h0);
    assign cur_first = steal && (left_q == 12'h001) && !fin_q;
    assign tw_adv    = axb_pkg::mul_alpha(tw_q);
    assign head_m    = ~({128{1'b1}} >> {rem_q, 3'b000});
    assign din       = fin_q ? ((in_word_in & head_m) | (hold_q & ~head_m)) : in_word_in;
    assign tw_use    = (cur_first && DECRYPT) ? tw_adv : tw_q;
    assign is_twk    = (st_q == axb_pkg::ST_TWK);
    assign last      = (rnd_q == axb_pkg::NROUNDS);
    assign rk_cur    = is_twk ? trk[rnd_q] : drk[DECRYPT ? (axb_pkg::NROUNDS - rnd_q) : rnd_q];
    assign first_key = DECRYPT ? drk[axb_pkg::NROUNDS] : drk[0];
    assign r_out     = (is_twk || !DECRYPT) ? axb_pkg::enc_round(blk_q, rk_cur, last)
                                            : axb_pkg::dec_round(blk_q, rk_cur, last);
    assign res       = r_out ^ twu_q;

    assign version_out        = ver_q;
    assign data_key_busy_out  = dk_busy;
    assign tweak_key_busy_out = tk_busy;
    assign op_busy_out        = busy_q;
    assign op_done_out        = done_q;
    assign in_word_read_out   = rd_q;
    assign out_valid_out      = ov_q;
    assign out_word_out       = od_q;

    // Sequencer: one round per clock, blocks handled one at a time for small area
    always_ff @(posedge clk_in or negedge sys_rst_n_in)
    begin
        if (!sys_rst_n_in)
        begin
            st_q <= axb_pkg::ST_IDLE;
            blk_q <= '0; tw_q <= '0; twu_q <= '0; hold_q <= '0; od_q <= '0;
            left_q <= 12'h000; rnd_q <= 4'h0; rem_q <= 4'h0;
            kf_q <= 1'b0; kfin_q <= 1'b0; fin_q <= 1'b0;
            busy_q <= 1'b0; done_q <= 1'b0; rd_q <= 1'b0; ov_q <= 1'b0;
            ver_q <= axb_pkg::VERSION;
        end
        else
        begin
            done_q <= 1'b0;
            rd_q   <= 1'b0;
            ov_q   <= 1'b0;
            if (done_q) busy_q <= 1'b0;                                     // Busy drops after done
            unique case (st_q)
                axb_pkg::ST_IDLE:
                    if (start_ok)
                    begin
                        busy_q <= 1'b1;
                        left_q <= req.msg_byte_count[15:4];
                        rem_q  <= req.msg_byte_count[3:0];
                        fin_q  <= 1'b0;
                        blk_q  <= req.init_vector ^ trk[0];
                        rnd_q  <= 4'h1;
                        st_q   <= axb_pkg::ST_TWK;
                    end
                axb_pkg::ST_TWK:
                begin
                    blk_q <= r_out;
                    rnd_q <= rnd_q + 4'h1;
                    if (last)
                    begin
                        tw_q <= r_out;
                        rd_q <= 1'b1;
                        st_q <= axb_pkg::ST_READ;
                    end
                end
                axb_pkg::ST_READ:
                begin
                    blk_q  <= din ^ tw_use ^ first_key;
                    twu_q  <= tw_use;
                    kf_q   <= cur_first;
                    kfin_q <= fin_q;
                    if (!fin_q) left_q <= left_q - 12'h001;
                    if (!(cur_first && DECRYPT) && !fin_q) tw_q <= tw_adv;
                    rnd_q  <= 4'h1;
                    st_q   <= axb_pkg::ST_CIPH;
                end
                axb_pkg::ST_CIPH:
                begin
                    blk_q <= r_out;
                    rnd_q <= rnd_q + 4'h1;
                    if (last && kf_q)
                    begin
                        hold_q <= res;
                        fin_q  <= 1'b1;
                        rd_q   <= 1'b1;
                        st_q   <= axb_pkg::ST_READ;
                    end
                    else if (last)
                    begin
                        ov_q <= 1'b1;
                        od_q <= res;
                        if (kfin_q)
                            st_q <= axb_pkg::ST_TAIL;
                        else if (left_q == 12'h000)
                        begin
                            done_q <= 1'b1;
                            st_q   <= axb_pkg::ST_IDLE;
                        end
                        else
                        begin
                            rd_q <= 1'b1;
                            st_q <= axb_pkg::ST_READ;
                        end
                    end
                end
                axb_pkg::ST_TAIL:
                begin
                    ov_q   <= 1'b1;
                    od_q   <= hold_q & head_m;
                    done_q <= 1'b1;
                    st_q   <= axb_pkg::ST_IDLE;
                end
                default:
                    st_q <= axb_pkg::ST_IDLE;
            endcase
        end
    end
endmodule

// ==== verif/axb_xts_asserts.sv ====
/* Handshake checker for the XTS core.
   Bound onto every axb_xts_core instance; sees only that instance's ports. */
`timescale 1ns/1ps
module axb_xts_asserts (
    input  wire logic        clk_in,             // System clock
    input  wire logic        sys_rst_n_in,       // Reset, low
    input  wire logic [31:0] version_out,        // Version value
    input  wire logic        data_key_valid_in,  // Data key request
    input  wire logic        data_key_busy_out,  // Data key setting
    input  wire logic        data_key_done_out,  // Data key last cycle
    input  wire logic        tweak_key_valid_in, // Tweak key request
    input  wire logic        tweak_key_busy_out, // Tweak key setting
    input  wire logic        tweak_key_done_out, // Tweak key last cycle
    input  wire logic        op_start_in,        // Start request
    input  wire logic        op_busy_out,        // Operation running
    input  wire logic        op_done_out,        // Operation last cycle
    input  wire logic        in_word_read_out,   // Read strobe
    input  wire logic        out_valid_out       // Output strobe
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!sys_rst_n_in);

    // Fourteen busy cycles, split in two runs to keep the repetition short
    sequence key_run(b);
        b[*7] ##1 b[*7];
    endsequence
    // A start the core must take: nothing running and no key being set
    sequence start_ok_s;
        op_start_in && !op_busy_out && !data_key_busy_out && !tweak_key_busy_out;
    endsequence

    version_const_a: assert property (version_out == axb_pkg::VERSION) else $error("version changed");
    dkey_len_a: assert property (data_key_valid_in && !data_key_busy_out && !op_busy_out |=>
        key_run(data_key_busy_out) ##1 !data_key_busy_out) else $error("data key busy length");
    dkey_done_a: assert property ($rose(data_key_busy_out) |-> ##13 data_key_done_out ##1 !data_key_done_out)
        else $error("data key done misplaced");
    twk_len_a: assert property (tweak_key_valid_in && !tweak_key_busy_out && !op_busy_out |=>
        key_run(tweak_key_busy_out) ##1 !tweak_key_busy_out) else $error("tweak key busy length");
    twk_done_a: assert property ($rose(tweak_key_busy_out) |-> ##13 tweak_key_done_out ##1 !tweak_key_done_out)
        else $error("tweak key done misplaced");
    start_take_a: assert property (start_ok_s |=> op_busy_out ##14 in_word_read_out)
        else $error("start not taken as expected");
    start_refuse_a: assert property (op_start_in && !op_busy_out && (data_key_busy_out || tweak_key_busy_out)
        |=> !op_busy_out) else $error("start taken during key setting");
    done_end_a: assert property (op_done_out |-> out_valid_out ##1 (!op_busy_out && !op_done_out))
        else $error("done not a final single cycle");
    read_result_a: assert property (in_word_read_out |-> ##15 (out_valid_out || in_word_read_out))
        else $error("read not followed by result");
    strobe_busy_a: assert property ((in_word_read_out || out_valid_out) |-> op_busy_out)
        else $error("strobe outside operation");
endmodule

// ==== verif/axb_user_src.sv ====
/* User-side data source for one XTS core: answers each read strobe with the next word.
   Assumes the bench loads words_in before it starts an operation. */
`timescale 1ns/1ps
module axb_user_src (
    input  wire logic              clk_in,          // System clock
    input  wire logic              sys_rst_n_in,    // Reset, low
    input  wire logic              op_start_in,     // Rewinds the word index
    input  wire logic              in_word_read_in, // Core read strobe
    input  wire logic [3:0][127:0] words_in,        // Message words in order
    output logic      [127:0]      in_word_out      // Word to the core
);
    logic [1:0]   idx_q;
    logic [127:0] last_q;

    // Valid only in a read cycle; otherwise the inverse, so a late sample shows up as wrong data
    assign in_word_out = in_word_read_in ? words_in[idx_q] : ~last_q;

    // Successive reads take successive words
    always_ff @(posedge clk_in or negedge sys_rst_n_in)
    begin
        if (!sys_rst_n_in)
        begin
            idx_q  <= 2'h0;
            last_q <= 128'h0;
        end
        else if (in_word_read_in)
        begin
            idx_q  <= idx_q + 2'h1;
            last_q <= in_word_out;
        end
        else if (op_start_in)
            idx_q <= 2'h0;
    end
endmodule

// ==== verif/axb_tb.sv ====
/* Self-checking bench: an encrypt and a decrypt core, each fed by a user data source.
   Assumes the checker and the data source compile first; round trips stand in for cipher vectors. */
`timescale 1ns/1ps
module tb;
    logic                clk_in;
    logic                rst_n;
    logic                dkv [2], tkv [2], start [2];
    logic [255:0]        dkey, tkey;
    axb_pkg::axb_req_t   req [2];
    logic [3:0][127:0]   words [2];
    logic [127:0]        in_w [2], ow [2];
    logic [31:0]         ver [2];
    logic                dkb [2], dkd [2], tkb [2], tkd [2], ob [2], od [2], rd [2], ov [2];
    logic [127:0]        oq [2][$];
    int                  bad_count, tests_run;

    // Index 0 encrypts, index 1 decrypts
    for (genvar g = 0; g < 2; g++)
    begin : g_dir
        axb_xts_core #(.DECRYPT(g == 1)) axb_xts_core_inst (.clk_in(clk_in), .sys_rst_n_in(rst_n),
            .version_out(ver[g]), .data_key_valid_in(dkv[g]), .data_key_in(dkey), .data_key_busy_out(dkb[g]),
            .data_key_done_out(dkd[g]), .tweak_key_valid_in(tkv[g]), .tweak_key_in(tkey),
            .tweak_key_busy_out(tkb[g]), .tweak_key_done_out(tkd[g]), .op_start_in(start[g]),
            .init_vector_in(req[g].init_vector), .msg_byte_count_in(req[g].msg_byte_count),
            .op_busy_out(ob[g]), .op_done_out(od[g]), .in_word_read_out(rd[g]), .in_word_in(in_w[g]),
            .out_valid_out(ov[g]), .out_word_out(ow[g]));
        axb_user_src axb_user_src_inst (.clk_in(clk_in), .sys_rst_n_in(rst_n), .op_start_in(start[g]),
            .in_word_read_in(rd[g]), .words_in(words[g]), .in_word_out(in_w[g]));
    end

    // Clock and output capture; capture on the falling edge, where outputs have settled
    always #25 clk_in = ~clk_in;
    always @(negedge clk_in)
        for (int i = 0; i < 2; i++)
            if (ov[i] === 1'b1)
                oq[i].push_back(ow[i]);

    task automatic step;
        @(posedge clk_in);
        #2;
    endtask
    task automatic fail(string m);
        bad_count++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask
    task automatic chk_bit(logic got, logic exp, string m);
        tests_run++;
        if (got !== exp) fail(m);
    endtask
    task automatic chk_word(logic [127:0] got, logic [127:0] exp, string m);
        tests_run++;
        if (got !== exp) fail(m);
    endtask
    task automatic chk_num(int got, int exp, string m);
        tests_run++;
        if (got != exp) fail(m);
    endtask
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Both keys at once, with a refused request for each key and a refused start mid-setting
    task automatic set_keys(int i);
        int n = 0, d = 0, m = 0, e = 0;
        dkv[i] = 1'b1;
        tkv[i] = 1'b1;
        step;
        for (int k = 0; k < 16; k++)
        begin
            dkv[i] = (k == 2);
            tkv[i] = (k == 4);
            start[i] = (k == 3);
            n += (dkb[i] === 1'b1);
            m += (tkb[i] === 1'b1);
            if (dkd[i] === 1'b1) d = n;
            if (tkd[i] === 1'b1) e = m;
            step;
            chk_bit(ob[i], 1'b0, "start taken during key setting");
        end
        chk_num(n, 14, "data key busy length");
        chk_num(d, 14, "data key done cycle");
        chk_num(m, 14, "tweak key busy length");
        chk_num(e, 14, "tweak key done cycle");
        $display("test key setting %0d done", i);
    endtask

    // One operation; cycle 1 is the first after the start edge
    task automatic run_op(int i, int cnt);
        int c = 1, fr = 0, b = (cnt + 15) / 16;
        oq[i].delete();
        req[i] = '{init_vector: 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0, msg_byte_count: 16'(cnt)};
        start[i] = 1'b1;
        step;
        start[i] = 1'b0;
        chk_bit(ob[i], 1'b1, "busy after start");
        while (od[i] !== 1'b1)
        begin
            if (rd[i] === 1'b1 && fr == 0) fr = c;
            step;
            c++;
            if (c > 200)
            begin
                fail("operation hang");
                end_sim;
            end
        end
        chk_bit(ov[i], 1'b1, "no output with done");
        chk_num(fr, 15, "first read cycle");
        chk_num(c, 15 + 15 * b + int'(cnt % 16 != 0), "done cycle");
        step;
        chk_bit(ob[i], 1'b0, "busy after done");
        chk_num(oq[i].size(), b, "output word count");
    endtask

    // Encrypt, then decrypt the result on the other build
    task automatic round_trip(int cnt);
        int r = cnt % 16;
        logic [127:0] mask;
        mask = (r == 0) ? '1 : ~128'h0 << (8 * (16 - r));
        run_op(0, cnt);
        chk_bit(oq[0][0] !== words[0][0], 1'b1, "data passed unciphered");
        chk_word(oq[0][oq[0].size() - 1] & ~mask, 128'h0, "stolen tail low bytes");
        for (int j = 0; j < 4; j++)
            words[1][j] = (j < oq[0].size()) ? oq[0][j] : 128'h0;
        run_op(1, cnt);
        for (int j = 0; j < oq[1].size(); j++)
            chk_word(oq[1][j], words[0][j] & ((j == oq[1].size() - 1) ? mask : '1), "round trip");
        $display("test round trip %0d bytes done", cnt);
    endtask

    initial
    begin
        clk_in = 1'b0;
        rst_n = 1'b0;
        dkv = '{2{1'b0}};
        tkv = '{2{1'b0}};
        start = '{2{1'b0}};
        dkey = {8{32'h1f2e3d4c}} ^ 256'h0123456789abcdef;
        tkey = {8{32'h5a6b7c8d}} ^ 256'hfedcba9876543210;
        req = '{2{'0}};
        words[1] = '0;
        for (int j = 0; j < 4; j++)
            words[0][j] = {8{16'ha5c3 ^ 16'(j * 16'h1111)}};
        bad_count = 0;
        tests_run = 0;
        repeat (8) step;
        for (int i = 0; i < 2; i++)
        begin
            chk_bit(dkb[i] | tkb[i] | ob[i] | rd[i] | ov[i], 1'b0, "not idle in reset");
            chk_word({96'h0, ver[i]}, {96'h0, axb_pkg::VERSION}, "version value");
        end
        rst_n = 1'b1;
        step;
        set_keys(0);
        set_keys(1);
        round_trip(16);
        round_trip(31);
        round_trip(47);
        round_trip(64);
        run_op(0, 16);
        words[1][0] = oq[0][0];
        run_op(0, 16);
        chk_word(oq[0][0], words[1][0], "back-to-back result differs");
        $display("test back to back done");
        start[0] = 1'b1;
        step;
        start[0] = 1'b0;
        repeat (20) step;
        rst_n = 1'b0;
        #1;
        chk_bit(ob[0] | rd[0] | od[0] | dkb[0], 1'b0, "not idle after mid-run reset");
        repeat (8) step;
        rst_n = 1'b1;
        set_keys(0);
        run_op(0, 16);
        chk_word(oq[0][0], words[1][0], "result after reset differs");
        $display("test mid-run reset done");
        end_sim;
    end
endmodule

bind axb_xts_core axb_xts_asserts axb_xts_asserts_inst (.clk_in(clk_in), .sys_rst_n_in(sys_rst_n_in),
    .version_out(version_out), .data_key_valid_in(data_key_valid_in), .data_key_busy_out(data_key_busy_out),
    .data_key_done_out(data_key_done_out), .tweak_key_valid_in(tweak_key_valid_in),
    .tweak_key_busy_out(tweak_key_busy_out), .tweak_key_done_out(tweak_key_done_out),
    .op_start_in(op_start_in), .op_busy_out(op_busy_out), .op_done_out(op_done_out),
    .in_word_read_out(in_word_read_out), .out_valid_out(out_valid_out));
